// File: bm_drop_counter.sv
`timescale 1ns/1ps
module buf_drop_counter (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // events
  input  wire logic        drop_evt,
  input  wire logic        rd_clear,
  input  wire logic        test_mode,
  // value
  output logic [31:0]      count
);
  import buf_mgr_pkg::*;

  logic [31:0] count_r;
  logic [31:0] count_nxt;

  // read clears (or loads test value); a drop in the read cycle is kept
  always_comb begin
    count_nxt = count_r;
    if (rd_clear) begin
      count_nxt = test_mode ? CNT_TEST_VALUE : 32'h0000_0000;
      if (drop_evt) begin
        count_nxt = count_nxt + 32'h0000_0001;
      end
    end else if (drop_evt && count_r != CNT_MAX) begin
      count_nxt = count_r + 32'h0000_0001;  // saturates
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= 32'h0000_0000;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

  sat_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (count_r == CNT_MAX && !rd_clear) |=> count_r == CNT_MAX)
    else $error("drop counter wrapped");
  test_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_clear && test_mode && !drop_evt) |=> count_r == CNT_TEST_VALUE)
    else $error("test pattern not loaded on read");

endmodule // buf_drop_counter

// File: bm_level_select.sv
`timescale 1ns/1ps
module buf_level_select (
  // usage per port
  input  wire logic [23:0]               usage,
  // configured pair
  input  wire buf_mgr_pkg::level_pair_t  levels,
  // chosen level, one per port view
  output logic [7:0]                     level,
  output logic [1:0]                     active_cnt
);
  import buf_mgr_pkg::*;

  // count ports at or above the active mark
  always_comb begin
    active_cnt = 2'd0;
    for (int i = 0; i < NPORTS; i++) begin
      if (usage[i*8 +: 8] >= ACTIVE_BUFFERS) begin
        active_cnt = active_cnt + 2'd1;
      end
    end
  end

  // two or more active picks the low value
  assign level = (active_cnt >= 2'd2) ? levels.low : levels.high;

endmodule // buf_level_select

// File: bm_port_model.sv
`timescale 1ns/1ps
module buf_port_model (
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // bench control
  input  wire logic [23:0]             target,
  input  wire logic                    fast,
  // towards the block
  input  wire buf_mgr_pkg::port_ctrl_t port_ctrl,
  output logic [23:0]                  port_usage,
  output logic [2:0]                   port_drop_evt
);
  import buf_mgr_pkg::*;
  logic [7:0] u;
  logic [7:0] t;
  // -------------------------------------------------------------
  // usage walks to target, one buffer a cycle or at once when fast
  // -------------------------------------------------------------
  // a refused buffer is a lost packet, so it pulses the drop event
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_usage <= '0;
      port_drop_evt <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        u = port_usage[8*p +: 8];
        t = target[8*p +: 8];
        port_drop_evt[p] <= t > u && port_ctrl.drop_block[p];
        if (t < u) begin
          u = fast ? t : u - 8'h01;
        end else if (t > u && !port_ctrl.drop_block[p]) begin
          u = fast ? t : u + 8'h01;
        end
        port_usage[8*p +: 8] <= u;
      end
    end
  end
endmodule // buf_port_model

// File: buffer_manager_config_pkg.sv
package buf_mgr_pkg;

  // ----------------------------------------------------------------
  // register map (offsets are word indices; byte address = 4*idx)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CONFIG    = 16'h1c00;
  localparam logic [15:0] IDX_DROP      = 16'h1c01;
  localparam logic [15:0] IDX_PAUSE     = 16'h1c02;
  localparam logic [15:0] IDX_RESUME    = 16'h1c03;
  localparam logic [15:0] IDX_DROPCNT0  = 16'h1c05;
  localparam logic [15:0] IDX_DROPCNT1  = 16'h1c06;
  localparam logic [15:0] IDX_DROPCNT2  = 16'h1c07;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_CNT_TEST_BIT  = 6;
  localparam int CFG_FIXED_PRI_BIT = 5;
  localparam int CFG_EGR_LSB       = 2;
  localparam int CFG_YELLOW_BIT    = 1;
  localparam int CFG_RED_BIT       = 0;
  localparam int CFG_WIDTH         = 7;
  localparam int LVL_LOW_LSB       = 8;
  localparam int LVL_HIGH_LSB      = 0;

  // ----------------------------------------------------------------
  // reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [6:0]  CFG_RST         = 7'h00;
  localparam logic [7:0]  DROP_LOW_RST    = 8'h49;
  localparam logic [7:0]  DROP_HIGH_RST   = 8'h64;
  localparam logic [7:0]  PAUSE_LOW_RST   = 8'h21;
  localparam logic [7:0]  PAUSE_HIGH_RST  = 8'h3c;
  localparam logic [7:0]  RESUME_LOW_RST  = 8'h03;
  localparam logic [7:0]  RESUME_HIGH_RST = 8'h07;
  localparam logic [7:0]  ACTIVE_BUFFERS  = 8'h24;       // 36 buffers
  localparam int          BUFFER_BYTES    = 128;         // bytes per buffer unit
  localparam logic [31:0] CNT_TEST_VALUE  = 32'h7fff_fffc;
  localparam logic [31:0] CNT_MAX         = 32'hffff_ffff;
  localparam logic [15:0] RESUME_PAUSE_TIME = 16'h0001;
  localparam int          NPORTS          = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] low;   // 2 or 3 ports active
    logic [7:0] high;  // 0 or 1 port active
  } level_pair_t;

  typedef struct packed {
    logic       cnt_test;
    logic       fixed_pri;
    logic [2:0] egress_pace;
    logic       drop_yellow;
    logic       drop_red;
  } mgr_config_t;

  typedef struct packed {
    logic [NPORTS-1:0] drop_block;   // refuse buffers
    logic [NPORTS-1:0] pause_req;    // pulse: send pause / backpressure
    logic [NPORTS-1:0] resume_req;   // pulse: send pause time 1
    logic [NPORTS-1:0] flow_held;    // level: flow control asserted
  } port_ctrl_t;

endpackage

// File: switch_buffer_manager_cfg.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module switch_buffer_manager_cfg (
  // clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // ahb-lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // ingress and egress packet paths
  input  wire logic [23:0]              port_usage,
  input  wire logic [2:0]               port_full_duplex,
  input  wire logic [2:0]               port_drop_evt,
  output buf_mgr_pkg::mgr_config_t      cfg_out,
  output buf_mgr_pkg::port_ctrl_t       port_ctrl,
  output logic [15:0]                   resume_pause_time
);
  import buf_mgr_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [15:0] byte_to_idx(input logic [31:0] a);
    byte_to_idx = a[17:2];
  endfunction

  // ----------------------------------------------------------------
  // bus slave: address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend_r, wr_pend_nxt;
  logic [15:0] idx_r, idx_nxt;
  logic        take;
  logic        rd_take;

  assign take    = hsel && hready && htrans[1];
  assign rd_take = take && !hwrite;

  // the write lands in the data phase, read data is registered here
  always_comb begin
    wr_pend_nxt = take && hwrite;
    idx_nxt     = take ? byte_to_idx(haddr) : idx_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      idx_r     <= 16'h0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      idx_r     <= idx_nxt;
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  mgr_config_t cfg_r, cfg_nxt;
  level_pair_t drop_r, drop_nxt;
  level_pair_t pause_r, pause_nxt;
  level_pair_t resume_r, resume_nxt;

  // whole-word writes only; reserved bits are dropped
  always_comb begin
    cfg_nxt    = cfg_r;
    drop_nxt   = drop_r;
    pause_nxt  = pause_r;
    resume_nxt = resume_r;
    if (wr_pend_r) begin
      case (idx_r)
        IDX_CONFIG: begin
          cfg_nxt = mgr_config_t'(hwdata[CFG_WIDTH-1:0]);
        end
        IDX_DROP: begin
          drop_nxt = level_pair_t'(hwdata[15:0]);
        end
        IDX_PAUSE: begin
          pause_nxt = level_pair_t'(hwdata[15:0]);
        end
        IDX_RESUME: begin
          resume_nxt = level_pair_t'(hwdata[15:0]);
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r    <= mgr_config_t'(CFG_RST);  // weighted round robin at reset
      drop_r   <= '{low: DROP_LOW_RST, high: DROP_HIGH_RST};
      pause_r  <= '{low: PAUSE_LOW_RST, high: PAUSE_HIGH_RST};
      resume_r <= '{low: RESUME_LOW_RST, high: RESUME_HIGH_RST};
    end else begin
      cfg_r    <= cfg_nxt;
      drop_r   <= drop_nxt;
      pause_r  <= pause_nxt;
      resume_r <= resume_nxt;
    end
  end

  // fixed_pri steers the egress scheduler, pacing enables per port
  assign cfg_out           = cfg_r;
  assign resume_pause_time = RESUME_PAUSE_TIME;

  // ----------------------------------------------------------------
  // drop counters
  // ----------------------------------------------------------------
  logic [31:0] cnt [NPORTS];
  logic [NPORTS-1:0] cnt_rd;

  for (genvar p = 0; p < NPORTS; p++) begin : g_cnt
    assign cnt_rd[p] = rd_take && byte_to_idx(haddr) == IDX_DROPCNT0 + 16'(p);
    buf_drop_counter u_cnt (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .drop_evt  (port_drop_evt[p]),
      .rd_clear  (cnt_rd[p]),
      .test_mode (cfg_r.cnt_test),
      .count     (cnt[p])
    );
  end

  // ----------------------------------------------------------------
  // read data (sampled at the address phase, so counter read sees old value)
  // ----------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;

  // configuration reads use the _nxt values: a back to back read whose address phase meets
  // the data phase of a write to the same register must see the new word
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_take) begin
      case (byte_to_idx(haddr))
        IDX_CONFIG:   rdata_nxt = {25'h0, cfg_nxt};
        IDX_DROP:     rdata_nxt = {16'h0, drop_nxt};
        IDX_PAUSE:    rdata_nxt = {16'h0, pause_nxt};
        IDX_RESUME:   rdata_nxt = {16'h0, resume_nxt};
        IDX_DROPCNT0: rdata_nxt = cnt[0];
        IDX_DROPCNT1: rdata_nxt = cnt[1];
        IDX_DROPCNT2: rdata_nxt = cnt[2];
        default:      rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;

  // ----------------------------------------------------------------
  // threshold selection by active port count
  // ----------------------------------------------------------------
  logic [7:0] drop_lvl, pause_lvl, resume_lvl;
  logic [1:0] active_cnt;

  buf_level_select u_sel_drop (
    .usage      (port_usage),
    .levels     (drop_r),
    .level      (drop_lvl),
    .active_cnt (active_cnt)
  );
  buf_level_select u_sel_pause (
    .usage      (port_usage),
    .levels     (pause_r),
    .level      (pause_lvl),
    .active_cnt ()
  );
  // resume uses high for 0 or 1 active, same split as the others
  buf_level_select u_sel_resume (
    .usage      (port_usage),
    .levels     (resume_r),
    .level      (resume_lvl),
    .active_cnt ()
  );

  // ----------------------------------------------------------------
  // flow control and drop gating (usage in 128-byte buffers)
  // ----------------------------------------------------------------
  logic [NPORTS-1:0] held_r, held_nxt;
  port_ctrl_t        ctrl_r, ctrl_nxt;

  // hysteresis: pause on reaching the pause level, release at resume level;
  // if software inverts the levels the port just toggles, hence the ordering advice
  always_comb begin
    held_nxt = held_r;
    ctrl_nxt = '0;
    for (int i = 0; i < NPORTS; i++) begin
      ctrl_nxt.drop_block[i] = port_usage[i*8 +: 8] >= drop_lvl;
      if (!held_r[i] && port_usage[i*8 +: 8] >= pause_lvl) begin
        held_nxt[i]           = 1'b1;
        ctrl_nxt.pause_req[i] = 1'b1;  // pause frame or backpressure
      end else if (held_r[i] && port_usage[i*8 +: 8] <= resume_lvl) begin
        held_nxt[i]            = 1'b0;
        ctrl_nxt.resume_req[i] = port_full_duplex[i];
      end
    end
    ctrl_nxt.flow_held = held_nxt;  // half duplex ports apply backpressure while held
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_r <= '0;
      ctrl_r <= '0;
    end else begin
      held_r <= held_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign port_ctrl = ctrl_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  drop_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (port_usage[7:0] >= drop_lvl) |=> port_ctrl.drop_block[0])
    else $error("port 0 not refused at drop level");
  pause_fire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!held_r[0] && port_usage[7:0] >= pause_lvl) |=> port_ctrl.pause_req[0])
    else $error("pause not raised");
  resume_fire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (held_r[0] && port_usage[7:0] <= resume_lvl && port_full_duplex[0])
      |=> port_ctrl.resume_req[0] && !port_ctrl.flow_held[0])
    else $error("resume not raised");
  level_pick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (active_cnt >= 2'd2) |-> drop_lvl == drop_r.low && pause_lvl == pause_r.low)
    else $error("low level not chosen");
  one_active_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (active_cnt < 2'd2) |-> drop_lvl == drop_r.high && resume_lvl == resume_r.high)
    else $error("high level not chosen");
  cfg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && idx_r == IDX_CONFIG) |=> cfg_out.fixed_pri == $past(hwdata[CFG_FIXED_PRI_BIT]))
    else $error("servicing bit not stored");
  pace_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && idx_r == IDX_CONFIG)
      |=> cfg_out.egress_pace == $past(hwdata[CFG_EGR_LSB +: 3]))
    else $error("pacing enables misplaced");
  rd_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && byte_to_idx(haddr) == IDX_DROP) |=> hrdata[31:16] == 16'h0000)
    else $error("reserved bits not zero");
  color_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && idx_r == IDX_CONFIG) |=> cfg_out.drop_yellow == $past(hwdata[CFG_YELLOW_BIT])
      && cfg_out.drop_red == $past(hwdata[CFG_RED_BIT]))
    else $error("discard enables not stored");
  // hysteresis on port 0, half duplex release on port 1, low drop level on port 2
  pause_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    held_r[0] |=> !port_ctrl.pause_req[0])
    else $error("second pause while held");
  hold_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (held_r[0] && port_usage[7:0] > resume_lvl) |=> port_ctrl.flow_held[0])
    else $error("flow control released early");
  half_duplex_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (held_r[1] && port_usage[15:8] <= resume_lvl && !port_full_duplex[1])
      |=> !port_ctrl.resume_req[1] && !port_ctrl.flow_held[1])
    else $error("half duplex release wrong");
  drop_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (active_cnt >= 2'd2 && port_usage[23:16] >= drop_r.low) |=> port_ctrl.drop_block[2])
    else $error("port 2 not refused at low drop level");

  pause_c: cover property (@(posedge hclk) disable iff (!hresetn) port_ctrl.pause_req[0]);
  resume_c: cover property (@(posedge hclk) disable iff (!hresetn) port_ctrl.resume_req[1]);
  two_active_c: cover property (@(posedge hclk) disable iff (!hresetn) active_cnt == 2'd2);
  cnt_read_c: cover property (@(posedge hclk) disable iff (!hresetn) cnt_rd[2] && cfg_r.cnt_test);
  drop_c: cover property (@(posedge hclk) disable iff (!hresetn) port_ctrl.drop_block[2]);

endmodule // switch_buffer_manager_cfg

// File: switch_buffer_manager_cfg_tb.sv
`timescale 1ns/1ps
module switch_buffer_manager_cfg_tb;
  import buf_mgr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, fast;
  logic [31:0] haddr, hwdata, hrdata, q, d, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pfd, pdrop;
  logic [23:0] usage, target, us;
  logic        hready;
  mgr_config_t cfg_out;
  port_ctrl_t  port_ctrl;
  logic [15:0] rpt;
  int          n_fail, checked, nd[3], np[3], nr[3];

  // -------------------------------------------------------------
  // design, far side and bus
  // -------------------------------------------------------------
  switch_buffer_manager_cfg dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
    .port_usage(usage), .port_full_duplex(pfd), .port_drop_evt(pdrop),
    .cfg_out(cfg_out), .port_ctrl(port_ctrl), .resume_pause_time(rpt));
  buf_port_model model_u (.hclk(hclk), .hresetn(hresetn), .target(target), .fast(fast),
    .port_ctrl(port_ctrl), .port_usage(usage), .port_drop_evt(pdrop));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // event counters; cleared by the bench only while the paths are quiet
  always @(posedge hclk) begin
    for (int p = 0; p < 3; p++) begin
      if (pdrop[p]) nd[p]++;
      if (port_ctrl.pause_req[p]) np[p]++;
      if (port_ctrl.resume_req[p]) nr[p]++;
    end
  end

  // -------------------------------------------------------------
  // tasks and expectations
  // -------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask

  // one single word transfer; the register index becomes a byte address
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    hsize <= 3'b010;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
  endtask

  // two or more ports at 36 buffers pick the low level
  function automatic logic [2:0] exp_block(input logic [23:0] u, input logic [15:0] lv);
    int act;
    logic [7:0] l;
    act = 0;
    for (int p = 0; p < 3; p++) if (u[8*p +: 8] >= 8'd36) act++;
    l = (act >= 2) ? lv[15:8] : lv[7:0];
    for (int p = 0; p < 3; p++) exp_block[p] = u[8*p +: 8] >= l;
  endfunction

  task automatic settle(input logic [23:0] t, input int cyc);
    target <= t;
    repeat (cyc) @(posedge hclk);
    #1;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; target = '0; fast = 1'b1; pfd = 3'b101;
    seed = $urandom(32'h450b);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    check("cfg_out rst", {25'h0, cfg_out}, 32'h0);
    bus(0, IDX_CONFIG, 0); check("config rst", q, 32'h0);
    bus(0, IDX_DROP, 0); check("drop rst", q, 32'h4964);
    bus(0, IDX_PAUSE, 0); check("pause rst", q, 32'h213c);
    bus(0, IDX_RESUME, 0); check("resume rst", q, 32'h0307);
    // config fields reach cfg_out; all ones first, then random, all zeros last
    for (int i = 0; i < 9; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 8) ? 32'h0 : $urandom;
      bus(1, IDX_CONFIG, d);
      #1;
      check("cfg_out", {25'h0, cfg_out}, {25'h0, d[6:0]});
      check("egress pace", {29'h0, cfg_out.egress_pace}, {29'h0, d[4:2]});
      bus(0, IDX_CONFIG, 0); check("config rd", q & 32'h7f, d & 32'h7f);
    end
    for (int i = 1; i < 4; i++) begin
      d = $urandom;
      bus(1, IDX_CONFIG + 16'(i), d);
      bus(0, IDX_CONFIG + 16'(i), 0); check("level rd", q & 32'hffff, d & 32'hffff);
    end
    // unmapped place ignores writes and reads zero
    bus(1, 16'h1c04, 32'hffff_ffff);
    bus(0, 16'h1c04, 0); check("unmapped", q, 32'h0);
    bus(1, IDX_DROP, 32'h4050);
    bus(1, IDX_PAUSE, 32'h3038);
    bus(1, IDX_RESUME, 32'h1014);
    // drop limits: boundaries of activity and levels, then random usage
    for (int i = 0; i < 16; i++) begin
      case (i)
        0: us = 24'h000000;
        1: us = 24'h232323;
        2: us = 24'h00004f;
        3: us = 24'h000050;
        4: us = 24'h00243f;
        5: us = 24'h002440;
        default: us = {8'($urandom % 96), 8'($urandom % 96), 8'($urandom % 96)};
      endcase
      settle(0, 2);
      settle(us, 4);
      check("drop block", {29'h0, port_ctrl.drop_block},
            {29'h0, exp_block(usage, 16'h4050)});
    end
    // flow control: port 1 half duplex, ports 0 and 2 full duplex
    settle(0, 4);
    for (int p = 0; p < 3; p++) begin
      np[p] = 0;
      nr[p] = 0;
    end
    fast <= 1'b0;
    settle(24'h3c0000, 80); check("pause one", np[2], 1);
    settle(24'h3c3c3c, 80); check("pause two", np[0] + np[1], 2);
    check("held", {29'h0, port_ctrl.flow_held}, 32'h7);
    settle(24'h003c3c, 80); check("resume low", nr[2], 1);
    settle(0, 80); check("resume high", nr[0] * 4 + nr[1], 4);
    check("released", {29'h0, port_ctrl.flow_held}, 32'h0);
    check("pause time", {16'h0, rpt}, 32'h1);
    // drop counter: counts refusals, clears on read, test load on read
    fast <= 1'b1;
    settle(0, 4);
    for (int p = 0; p < 3; p++) begin
      bus(0, IDX_DROPCNT0 + 16'(p), 0); check("drop count start", q, 32'(nd[p]));
    end
    for (int k = 0; k < 2; k++) begin
      nd[2] = 0;
      fast <= 1'b0;
      settle(24'h600000, 100);
      fast <= 1'b1;
      settle(0, 4);
      bus(0, IDX_DROPCNT2, 0); check("drop count", q, 32'(nd[2]));
      bus(0, IDX_DROPCNT2, 0); check("after read", q, k ? 32'h7fff_fffc : 32'h0);
      bus(1, IDX_CONFIG, 32'h40);
    end
    wrap_up();
  end
endmodule // switch_buffer_manager_cfg_tb
